// ---- pkg/lsp_regs.vh ----
// Register map, field positions and constants of the power-mode block
`ifndef LSP_REGS_VH
`define LSP_REGS_VH
// Register indices on the plain port
`define LSP_ADDR_PORTG 8'h00
`define LSP_ADDR_ICTL 8'h01
`define LSP_ADDR_ITMODE 8'h02
`define LSP_ADDR_CLKCTL 8'h03
`define LSP_ADDR_STAT 8'h04
// Port G data register fields
`define LSP_PG_IDLE 6
`define LSP_PG_HALT 7
// Interrupt control register fields
`define LSP_IC_EN 0
`define LSP_IC_PND 1
// Clock control register fields
`define LSP_CC_LSON 0
`define LSP_CC_DCEN 1
`define LSP_CC_HSOSC 2
`define LSP_CC_CKSEL 3
`define LSP_CC_DLY 4
// Reset values
`define LSP_PG_RST 6'h00
`define LSP_CC_RST 5'h04
`define LSP_SEL_RST 3'h0
`define LSP_RD_ZERO 8'h00
// Window select codes
`define LSP_WIN_0P125 3'h0
`define LSP_WIN_0P25 3'h1
`define LSP_WIN_0P5 3'h2
`define LSP_WIN_1 3'h3
`define LSP_WIN_2 3'h4
// Divider stage whose toggle period is the window (32768 Hz ticks)
`define LSP_STG_0P125 5'h0c
`define LSP_STG_0P25 5'h0d
`define LSP_STG_0P5 5'h0e
`define LSP_STG_1 5'h0f
`define LSP_STG_2 5'h10
`define LSP_DIV_W 17
`define LSP_DIV_RST 17'h0_0000
// Shortest idle in microseconds, one low-speed tick
`define LSP_MIN_IDLE_US 30
`endif

// ---- rtl/lsp_idle_div.v ----
// Free-running idle window divider with selected-stage toggle detect
`timescale 1ns/100ps
`default_nettype none
`include "lsp_regs.vh"
module lsp_idle_div (
  input wire clk_sys, // System clock
  input wire rst_n, // Synchronous reset, low
  input wire ls_tick, // One low-speed clock tick
  input wire run, // Divider clocked when high
  input wire [2:0] win_sel, // Window select code
  output wire win_toggle // Selected stage toggled
);
  reg [`LSP_DIV_W-1:0] div_r; // Divider chain
  reg sel_prev_r; // Selected stage last cycle
  reg [4:0] stage; // Stage index for the window
  wire sel_bit; // Selected stage value

  // Map window code to divider stage
  always @*
  begin
    if (win_sel == `LSP_WIN_0P125)
      stage = `LSP_STG_0P125;
    else if (win_sel == `LSP_WIN_0P25)
      stage = `LSP_STG_0P25;
    else if (win_sel == `LSP_WIN_0P5)
      stage = `LSP_STG_0P5;
    else if (win_sel == `LSP_WIN_1)
      stage = `LSP_STG_1;
    else
      stage = `LSP_STG_2;
  end

  assign sel_bit = div_r[stage];
  // Any change of the selected stage counts, so a window change may fire
  assign win_toggle = sel_bit ^ sel_prev_r;

  // Counts every tick, idle or not, stopped only by run low
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      div_r <= `LSP_DIV_RST;
      sel_prev_r <= 1'b0;
    end
    else
    begin
      if (ls_tick && run)
        div_r <= div_r + 1'b1;
      sel_prev_r <= sel_bit;
    end
  end
endmodule // lsp_idle_div
`default_nettype wire

// ---- rtl/lsp_power_ctl.v ----
// Low-speed clock mode, halt and idle control with idle window timer
`timescale 1ns/100ps
`default_nettype none
`include "lsp_regs.vh"
module lsp_power_ctl (
  input wire clk_sys, // System clock, 125 MHz
  input wire rst_n, // Reset pin, synchronous, low
  input wire [7:0] reg_addr, // Register index
  input wire [7:0] reg_wdata, // Write data
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  output reg [7:0] reg_rdata_r, // Read data, cycle after strobe
  input wire ls_tick, // Low-speed oscillator tick
  input wire wake_event, // Enabled multi-input wake-up pulse
  input wire halt_disable, // Halt-disable option
  input wire bit7_opt_ok, // Clock option frees bit 7 pin
  input wire port_g_bit_seven_input, // Port G bit 7 pin level
  output reg core_stop_r, // Core clocks stopped
  output reg core_ls_clk_r, // Core runs on low-speed clock
  output reg hs_osc_en_r, // High-speed oscillator enable
  output reg ls_osc_en_r, // Low-speed oscillator enable
  output reg irq_r, // Idle timer interrupt request
  output reg resume_r, // Pulse, core resumes
  output reg start_delay_r // Pulse, start-up delay needed
);
  // Clock mode states, one-hot
  localparam [2:0] MODE_HS = 3'b001;
  localparam [2:0] MODE_DUAL = 3'b010;
  localparam [2:0] MODE_LS = 3'b100;
  // Power states, one-hot
  localparam [3:0] PWR_RUN = 4'b0001;
  localparam [3:0] PWR_HPEND = 4'b0010;
  localparam [3:0] PWR_HALT = 4'b0100;
  localparam [3:0] PWR_IDLE = 4'b1000;

  reg [2:0] mode_r; // Clock mode
  reg [2:0] mode_nxt; // Next clock mode
  reg [3:0] pwr_r; // Power state
  reg [3:0] pwr_nxt; // Next power state
  reg [5:0] pg_low_r; // Port G data, plain bits
  reg [4:0] clk_ctl_r; // Clock control bits
  reg [2:0] idle_window_select; // Window select field
  reg idle_timer_irq_enable; // Interrupt enable bit
  reg idle_timer_pending_flag; // Pending flag
  reg [7:0] rdata_nxt; // Read mux
  reg resume_nxt; // Resume pulse next
  reg dly_nxt; // Start-up delay pulse next
  wire win_toggle; // Window elapsed event
  wire timer_run; // Divider clock gate
  wire wr_pg; // Port G write
  wire wr_ic; // Interrupt control write
  wire wr_itm; // Idle timer mode write
  wire wr_cc; // Clock control write
  wire halt_req; // Accepted halt request
  wire idle_req; // Accepted idle request

  // Register write decodes
  assign wr_pg = reg_wr && (reg_addr == `LSP_ADDR_PORTG);
  assign wr_ic = reg_wr && (reg_addr == `LSP_ADDR_ICTL);
  assign wr_itm = reg_wr && (reg_addr == `LSP_ADDR_ITMODE);
  assign wr_cc = reg_wr && (reg_addr == `LSP_ADDR_CLKCTL);

  // Halt bit is dropped when the option forbids halt
  assign halt_req = wr_pg && reg_wdata[`LSP_PG_HALT]
    && !halt_disable;
  assign idle_req = wr_pg && reg_wdata[`LSP_PG_IDLE];

  // Divider is held while halted, runs in idle and run
  assign timer_run = !pwr_r[2];

  // Idle window divider; no register reaches it
  lsp_idle_div u_div (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ls_tick(ls_tick),
    .run(timer_run),
    .win_sel(idle_window_select),
    .win_toggle(win_toggle)
  );

  // Software control registers
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pg_low_r <= `LSP_PG_RST;
      clk_ctl_r <= `LSP_CC_RST;
      idle_window_select <= `LSP_SEL_RST;
      idle_timer_irq_enable <= 1'b0;
    end
    else
    begin
      // Plain port G bits are stored as written
      if (wr_pg)
        pg_low_r <= reg_wdata[5:0];
      // Oscillator and clock select bits
      if (wr_cc)
        clk_ctl_r <= reg_wdata[4:0];
      // Window select, five legal codes
      if (wr_itm)
        idle_window_select <= reg_wdata[2:0];
      // Interrupt enable bit
      if (wr_ic)
        idle_timer_irq_enable <= reg_wdata[`LSP_IC_EN];
    end
  end

  // Pending flag: window event sets, software write of zero clears
  always @(posedge clk_sys)
  begin
    if (!rst_n)
      idle_timer_pending_flag <= 1'b0;
    else if (win_toggle)
      idle_timer_pending_flag <= 1'b1;
    else if (wr_ic && !reg_wdata[`LSP_IC_PND])
      idle_timer_pending_flag <= 1'b0;
  end

  // Clock mode next state
  always @*
  begin
    mode_nxt = mode_r;
    case (mode_r)
      MODE_HS:
      begin
        // Dual clock once low oscillator on and enabled
        if (clk_ctl_r[`LSP_CC_LSON] && clk_ctl_r[`LSP_CC_DCEN])
          mode_nxt = MODE_DUAL;
      end
      MODE_DUAL:
      begin
        // Low-speed only from here, select set and fast osc off
        if (clk_ctl_r[`LSP_CC_CKSEL] && !clk_ctl_r[`LSP_CC_HSOSC])
          mode_nxt = MODE_LS;
        else if (!clk_ctl_r[`LSP_CC_DCEN])
          mode_nxt = MODE_HS;
      end
      MODE_LS:
      begin
        // Back to dual when fast osc on and select cleared
        if (clk_ctl_r[`LSP_CC_HSOSC] && !clk_ctl_r[`LSP_CC_CKSEL])
          mode_nxt = MODE_DUAL;
      end
      default:
        mode_nxt = MODE_HS;
    endcase
  end

  // Power state next state and pulses
  always @*
  begin
    pwr_nxt = pwr_r;
    resume_nxt = 1'b0;
    dly_nxt = 1'b0;
    case (pwr_r)
      PWR_RUN:
      begin
        // Halt has priority over idle in one write
        if (halt_req)
          pwr_nxt = PWR_HPEND;
        else if (idle_req)
          pwr_nxt = PWR_IDLE;
      end
      PWR_HPEND:
      begin
        // Stop lands mid next instruction cycle
        pwr_nxt = PWR_HALT;
      end
      PWR_HALT:
      begin
        // Only wake-up leaves halt; reset pin handled by rst_n
        if (wake_event)
        begin
          pwr_nxt = PWR_RUN;
          resume_nxt = 1'b1;
          // Low-speed halt resumes with no delay at all
          dly_nxt = !mode_r[2];
        end
      end
      PWR_IDLE:
      begin
        // Window elapsed or wake-up ends idle
        if (win_toggle || wake_event)
        begin
          pwr_nxt = PWR_RUN;
          resume_nxt = 1'b1;
        end
      end
      default:
        pwr_nxt = PWR_RUN;
    endcase
  end

  // State registers
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      mode_r <= MODE_HS;
      pwr_r <= PWR_RUN;
    end
    else
    begin
      mode_r <= mode_nxt;
      pwr_r <= pwr_nxt;
    end
  end

  // Core-facing outputs, each from a flip-flop
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      core_stop_r <= 1'b0;
      core_ls_clk_r <= 1'b0;
      hs_osc_en_r <= 1'b1;
      ls_osc_en_r <= 1'b0;
      irq_r <= 1'b0;
      resume_r <= 1'b0;
      start_delay_r <= 1'b0;
    end
    else
    begin
      core_stop_r <= pwr_nxt[2] || pwr_nxt[3];
      // Switch straight over, oscillator already running
      core_ls_clk_r <= mode_nxt[2];
      // Fast oscillator follows its enable outside low-speed
      hs_osc_en_r <= clk_ctl_r[`LSP_CC_HSOSC] && !mode_nxt[2];
      // Low oscillator kept on in low-speed, halt included
      ls_osc_en_r <= clk_ctl_r[`LSP_CC_LSON]
        || !mode_nxt[0];
      // Request held with pending; core takes it after the
      // instruction begun at idle entry has finished
      irq_r <= idle_timer_irq_enable
        && (idle_timer_pending_flag || win_toggle);
      resume_r <= resume_nxt;
      start_delay_r <= dly_nxt;
    end
  end

  // Read mux; unmapped indices read zero
  always @*
  begin
    rdata_nxt = `LSP_RD_ZERO;
    if (reg_addr == `LSP_ADDR_PORTG)
    begin
      rdata_nxt[5:0] = pg_low_r;
      rdata_nxt[`LSP_PG_IDLE] = pwr_r[3];
      // Pin reads only when the clock option frees it
      rdata_nxt[`LSP_PG_HALT] = port_g_bit_seven_input
        && bit7_opt_ok;
    end
    else if (reg_addr == `LSP_ADDR_ICTL)
    begin
      rdata_nxt[`LSP_IC_EN] = idle_timer_irq_enable;
      rdata_nxt[`LSP_IC_PND] = idle_timer_pending_flag;
    end
    else if (reg_addr == `LSP_ADDR_ITMODE)
      rdata_nxt[2:0] = idle_window_select;
    else if (reg_addr == `LSP_ADDR_CLKCTL)
      rdata_nxt[4:0] = clk_ctl_r;
    else if (reg_addr == `LSP_ADDR_STAT)
    begin
      rdata_nxt[2:0] = mode_r;
      rdata_nxt[6:3] = pwr_r;
    end
  end

  // Read data valid only in the cycle after the strobe
  always @(posedge clk_sys)
  begin
    if (!rst_n)
      reg_rdata_r <= `LSP_RD_ZERO;
    else if (reg_rd)
      reg_rdata_r <= rdata_nxt;
    else
      reg_rdata_r <= `LSP_RD_ZERO;
  end
endmodule // lsp_power_ctl
`default_nettype wire

// ---- tb/lsp_power_ctl_properties.sv ----
// Port-level checks of the power-mode block
`timescale 1ns/100ps
`default_nettype none
`include "lsp_regs.vh"
module lsp_props (
  input wire logic clk_sys, // Clock
  input wire logic rst_n, // Reset, low
  input wire logic [7:0] reg_addr, // Index
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata_r, // Read data
  input wire logic wake_event, // Wake pulse
  input wire logic halt_disable, // Halt option
  input wire logic core_stop_r, // Stopped
  input wire logic core_ls_clk_r, // Low-speed core
  input wire logic hs_osc_en_r, // Fast osc
  input wire logic ls_osc_en_r, // Slow osc
  input wire logic irq_r, // Interrupt
  input wire logic resume_r, // Resume pulse
  input wire logic start_delay_r // Delay pulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  reg en_q; // Mirror of the interrupt enable
  // Follow enable writes
  always @(posedge clk_sys)
    if (!rst_n)
      en_q <= 1'b0;
    else if (reg_wr && reg_addr == `LSP_ADDR_ICTL)
      en_q <= reg_wdata[0];
  // Lone halt write while running
  sequence s_halt_wr;
    reg_wr && reg_addr == `LSP_ADDR_PORTG && reg_wdata == 8'h80 &&
      !core_stop_r && !$past(reg_wr);
  endsequence
  // Resume is a single pulse
  sequence s_resume;
    resume_r ##1 !resume_r;
  endsequence
  a_halt_entry: assert property (s_halt_wr ##0 !halt_disable ##1
    !wake_event[*2] |-> ##[0:1] core_stop_r) else $error("no halt");
  a_halt_ignored: assert property (s_halt_wr ##0 halt_disable
    |=> !core_stop_r[*2]) else $error("halt taken");
  a_wake_resume: assert property (core_stop_r && wake_event
    |-> ##[1:2] s_resume) else $error("no resume");
  a_ls_no_delay: assert property (resume_r && core_ls_clk_r
    |-> !start_delay_r) else $error("delay in low speed");
  a_ls_from_dual: assert property ($rose(core_ls_clk_r)
    |-> $past(ls_osc_en_r)) else $error("bad low speed entry");
  a_ls_osc_kept: assert property (core_ls_clk_r
    |-> ls_osc_en_r) else $error("slow osc off");
  a_irq_gated: assert property (irq_r
    |-> en_q || $past(en_q)) else $error("irq while disabled");
  a_timer_hidden: assert property ($past(reg_rd) &&
    $past(reg_addr) > `LSP_ADDR_STAT |-> reg_rdata_r == 8'h00)
    else $error("unmapped read not zero");
  a_reset_hs: assert property ($rose(rst_n) |-> hs_osc_en_r &&
    !core_ls_clk_r && !core_stop_r) else $error("reset mode");
endmodule // lsp_props
bind lsp_power_ctl lsp_props u_props (.clk_sys, .rst_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r, .wake_event, .halt_disable,
  .core_stop_r, .core_ls_clk_r, .hs_osc_en_r, .ls_osc_en_r, .irq_r,
  .resume_r, .start_delay_r);
`default_nettype wire

// ---- tb/lsp_osc_model.sv ----
// Low-speed oscillator and wake-up pin model facing the block
`timescale 1ns/100ps
`default_nettype none
module lsp_osc_model (
  input wire logic clk_sys, // Clock
  input wire logic tick_en, // Run oscillator
  input wire logic wake_req, // Fire a wake-up
  output logic ls_tick, // Tick pulse
  output logic wake_event // Wake pulse
);
  // Ticks never gated by core state, wake only registered
  always @(posedge clk_sys)
  begin
    ls_tick <= tick_en;
    wake_event <= wake_req;
  end
endmodule // lsp_osc_model
`default_nettype wire

// ---- tb/tb_lsp_power_ctl.sv ----
// Self-checking bench for the power-mode block
`timescale 1ns/100ps
`default_nettype none
`include "lsp_regs.vh"
module tb_lsp_power_ctl;
  logic clk_sys, rst_n, reg_wr, reg_rd, tick_en, wake_req; // Drives
  logic halt_disable, bit7_opt_ok, pin_bit7, sd_seen; // Options, flags
  logic [7:0] reg_addr, reg_wdata, reg_rdata_r; // Bus
  logic ls_tick, wake_event, core_stop_r, core_ls_clk_r; // Links
  logic hs_osc_en_r, ls_osc_en_r, irq_r, resume_r, start_delay_r; // Outs
  int err_total, checks, cyc, n, i; // Counters
  lsp_power_ctl dut_u (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata_r, .ls_tick, .wake_event, .halt_disable,
    .bit7_opt_ok, .port_g_bit_seven_input(pin_bit7), .core_stop_r,
    .core_ls_clk_r, .hs_osc_en_r, .ls_osc_en_r, .irq_r, .resume_r,
    .start_delay_r);
  lsp_osc_model osc_u (.clk_sys, .tick_en, .wake_req, .ls_tick,
    .wake_event);
  initial
  begin
    clk_sys = 0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Cycle ceiling and start-up delay capture
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (start_delay_r === 1'b1)
      sd_seen <= 1'b1;
    if (cyc == 90000)
    begin
      err_total++;
      conclude;
    end
  end
  task automatic chk(input logic [7:0] g, e);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(reg_rdata_r, e);
  endtask
  // Clear pending, enter idle, count cycles stopped
  task automatic idle_run(input logic [7:0] ic, output int cnt);
    wr(`LSP_ADDR_ICTL, ic);
    wr(`LSP_ADDR_PORTG, 8'h40);
    repeat (2) @(negedge clk_sys);
    cnt = 0;
    while (core_stop_r === 1'b1 && cnt < 70000)
    begin
      @(negedge clk_sys);
      cnt++;
    end
  endtask
  task automatic wake;
    @(posedge clk_sys);
    wake_req <= 1'b1;
    @(posedge clk_sys);
    wake_req <= 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    {rst_n, reg_wr, reg_rd, wake_req, halt_disable, bit7_opt_ok} = '0;
    {pin_bit7, sd_seen, tick_en} = 3'b101;
    {reg_addr, reg_wdata} = '0;
    err_total = 0;
    checks = 0;
    cyc = 0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(`LSP_ADDR_CLKCTL, 8'h04);
    rd(`LSP_ADDR_STAT, 8'h09);
    rd(8'h05, 8'h00);
    wr(`LSP_ADDR_PORTG, 8'h15);
    rd(`LSP_ADDR_PORTG, 8'h15);
    wr(`LSP_ADDR_ITMODE, 8'h03);
    bit7_opt_ok <= 1'b1;
    halt_disable <= 1'b1;
    rd(`LSP_ADDR_PORTG, 8'h95);
    rd(`LSP_ADDR_ITMODE, 8'h03);
    $display("test registers done");
    wr(`LSP_ADDR_ITMODE, 8'h00);
    wr(`LSP_ADDR_PORTG, 8'h80);
    repeat (4) @(posedge clk_sys);
    halt_disable <= 1'b0;
    @(negedge clk_sys);
    chk(core_stop_r, 8'h00);
    wr(`LSP_ADDR_ICTL, 8'h00);
    wr(`LSP_ADDR_PORTG, 8'h80);
    repeat (5000) @(posedge clk_sys);
    rd(`LSP_ADDR_STAT, 8'h21);
    rd(`LSP_ADDR_ICTL, 8'h00);
    wake;
    chk(core_stop_r, 8'h00);
    chk(sd_seen, 8'h01);
    $display("test halt done");
    for (i = 0; i < 3; i++)
    begin
      wr(`LSP_ADDR_ITMODE, 8'(i));
      idle_run(8'h00, n);
      idle_run(8'h00, n);
      chk(8'(n >= (4096 << i) - 12 && n <= (4096 << i)), 8'h01);
      chk(irq_r, 8'h00);
    end
    wr(`LSP_ADDR_ITMODE, 8'h00);
    idle_run(8'h01, n);
    repeat (3) @(negedge clk_sys);
    chk(irq_r, 8'h01);
    rd(`LSP_ADDR_ICTL, 8'h03);
    $display("test idle done");
    wr(`LSP_ADDR_ICTL, 8'h00);
    wr(`LSP_ADDR_PORTG, 8'h40);
    wake;
    chk(core_stop_r, 8'h00);
    $display("test wake done");
    wr(`LSP_ADDR_CLKCTL, 8'h09);
    rd(`LSP_ADDR_STAT, 8'h09);
    wr(`LSP_ADDR_CLKCTL, 8'h07);
    rd(`LSP_ADDR_STAT, 8'h0a);
    wr(`LSP_ADDR_CLKCTL, 8'h0f);
    wr(`LSP_ADDR_CLKCTL, 8'h0b);
    rd(`LSP_ADDR_STAT, 8'h0c);
    chk({core_ls_clk_r, hs_osc_en_r, ls_osc_en_r}, 8'h05);
    sd_seen <= 1'b0;
    wr(`LSP_ADDR_PORTG, 8'h80);
    repeat (4) @(posedge clk_sys);
    wake;
    chk(core_stop_r, 8'h00);
    chk(sd_seen, 8'h00);
    wr(`LSP_ADDR_CLKCTL, 8'h07);
    rd(`LSP_ADDR_STAT, 8'h0a);
    wr(`LSP_ADDR_CLKCTL, 8'h0f);
    wr(`LSP_ADDR_CLKCTL, 8'h0b);
    rd(`LSP_ADDR_STAT, 8'h0c);
    wr(`LSP_ADDR_PORTG, 8'h80);
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({core_stop_r, ls_osc_en_r}, 8'h03);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(`LSP_ADDR_STAT, 8'h09);
    chk({core_stop_r, core_ls_clk_r, hs_osc_en_r}, 8'h01);
    $display("test low speed done");
    conclude;
  end
endmodule // tb_lsp_power_ctl
`default_nettype wire
